// File: rtl/vlan_policy_pkg.sv
package vlan_policy_pkg;

  // Register word addresses: printed offsets are not all multiples of four,
  // so they are indices and the byte address is four times the index.
  localparam logic [7:0] POLICY_FOUR_IDX  = 8'h05;
  localparam logic [7:0] POLICY_FIVE_IDX  = 8'h06;

  // Reset values
  localparam logic [7:0] POLICY_FOUR_RST  = 8'hc0;
  localparam logic [7:0] POLICY_FIVE_RST  = 8'h10;

  // Writable bit masks; reserved bits of the fourth register
  // (bit 0) and fifth (bits 7, 5, 1) read as zero.
  localparam logic [7:0] POLICY_FOUR_MASK = 8'hfe;
  localparam logic [7:0] POLICY_FIVE_MASK = 8'h5d;

  // Field positions, fourth register
  localparam int MEMBER_ACT_HI   = 7;
  localparam int MEMBER_ACT_LO   = 6;
  localparam int GVRP_TRAP_BIT   = 5;
  localparam int GMRP_TRAP_BIT   = 4;
  localparam int DT_SEL_HI       = 3;
  localparam int DT_SEL_LO       = 2;
  localparam int RSV_FLOOD_BIT   = 1;

  // Field positions, fifth register
  localparam int TAG_KEEP_BIT    = 6;
  localparam int TRUNK_SKIP_BIT  = 4;
  localparam int INVALID_DROP_BIT = 3;
  localparam int ALL_ONES_FWD_BIT = 2;
  localparam int MGMT_CRC_SKIP_BIT = 0;

  // Membership failure actions
  typedef enum logic [1:0] {
    MEMBER_FWD_NOLEARN = 2'b00,
    MEMBER_DROP        = 2'b01,
    MEMBER_FWD_LEARN   = 2'b10,
    MEMBER_TO_MGMT     = 2'b11
  } member_act_e;

  // Double tag mode select encodings
  localparam logic [1:0] DT_SEL_OFF = 2'b00;
  localparam logic [1:0] DT_SEL_ON  = 2'b01;

  // Reserved group address prefix and last-byte range
  localparam logic [39:0] RSV_PREFIX   = 40'h0180c20000;
  localparam logic [7:0]  RSV_LOW_ONE  = 8'h00;
  localparam logic [7:0]  RSV_RANGE_LO = 8'h02;
  localparam logic [7:0]  RSV_RANGE_HI = 8'h2f;

  localparam logic [11:0] VID_ALL_ONES = 12'hfff;

endpackage

// File: rtl/vlan_global_policy_ctrl.sv
// Register access over Wishbone was decided locally.
module vlan_global_policy_ctrl
  import vlan_policy_pkg::*;
(
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [9:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // Frame description, valid with frame_valid_i
  input  wire logic        frame_valid_i,
  input  wire logic        from_mgmt_i,
  input  wire logic [47:0] dest_mac_i,
  input  wire logic [11:0] vid_i,
  input  wire logic        vid_hit_i,
  input  wire logic        source_listed_i,
  input  wire logic        is_gvrp_i,
  input  wire logic        is_gmrp_i,
  input  wire logic        is_1q_tagged_i,
  input  wire logic        egress_directed_i,
  input  wire logic        crc_ok_i,
  // Decision, registered one cycle after frame_valid_i
  output logic             decision_valid_o,
  output logic             drop_o,
  output logic             to_mgmt_o,
  output logic             mgmt_only_o,
  output logic             learn_o,
  output logic             flood_rsv_o,
  output logic             keep_tag_o,
  output logic             trunk_check_o,
  output logic             double_tag_o
);

  logic [7:0] policy_four;
  logic [7:0] policy_five;

  // Bus decode
  wire        bus_req    = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire [7:0]  word_idx   = wb_adr_i[9:2];
  wire        hit_four   = (word_idx == POLICY_FOUR_IDX);
  wire        hit_five   = (word_idx == POLICY_FIVE_IDX);
  wire        hit_any    = hit_four | hit_five;
  wire        wr_lane0   = bus_req & wb_we_i & wb_sel_i[0];
  wire [7:0]  rd_word    = hit_four ? policy_four : (hit_five ? policy_five : 8'h00);

  // Answer in the cycle after the request; unmapped addresses get err
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req & hit_any;
      wb_err_o <= bus_req & ~hit_any;
      wb_dat_o <= (bus_req & ~wb_we_i) ? {24'h00_0000, rd_word} : 32'h0000_0000;
    end
  end

  // Only byte lane 0 carries register data
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      policy_four <= POLICY_FOUR_RST;
      policy_five <= POLICY_FIVE_RST;
    end else begin
      if (wr_lane0 && hit_four) begin
        policy_four <= wb_dat_i[7:0] & POLICY_FOUR_MASK;
      end
      if (wr_lane0 && hit_five) begin
        policy_five <= wb_dat_i[7:0] & POLICY_FIVE_MASK;
      end
    end
  end

  // Field views
  member_act_e member_act;
  assign member_act = member_act_e'(policy_four[MEMBER_ACT_HI:MEMBER_ACT_LO]);
  wire [1:0] dt_sel       = policy_four[DT_SEL_HI:DT_SEL_LO];
  // Reserved encodings are treated as disabled; software must not write them
  wire       dt_on        = (dt_sel == DT_SEL_ON);
  wire       gvrp_trap    = policy_four[GVRP_TRAP_BIT];
  wire       gmrp_trap    = policy_four[GMRP_TRAP_BIT];
  wire       rsv_flood    = policy_four[RSV_FLOOD_BIT];
  wire       tag_keep     = policy_five[TAG_KEEP_BIT];
  wire       trunk_skip   = policy_five[TRUNK_SKIP_BIT];
  wire       invalid_drop = policy_five[INVALID_DROP_BIT];
  wire       all_ones_fwd = policy_five[ALL_ONES_FWD_BIT];
  wire       crc_skip     = policy_five[MGMT_CRC_SKIP_BIT];

  // Classification
  wire [7:0] last_byte   = dest_mac_i[7:0];
  wire       rsv_group   = (dest_mac_i[47:8] == RSV_PREFIX) &&
                           ((last_byte == RSV_LOW_ONE) ||
                            ((last_byte >= RSV_RANGE_LO) &&
                             (last_byte <= RSV_RANGE_HI)));
  wire       member_fail = vid_hit_i & ~source_listed_i;
  wire       check_src   = member_fail & ~from_mgmt_i;
  wire       vid_invalid = ~vid_hit_i;
  wire       vid_ones    = (vid_i == VID_ALL_ONES);
  wire       crc_bad     = ~crc_ok_i & ~(from_mgmt_i & crc_skip);

  // Membership action decode
  wire       mem_drop    = check_src & (member_act == MEMBER_DROP);
  wire       mem_mgmt    = check_src & (member_act == MEMBER_TO_MGMT);
  wire       mem_nolearn = check_src & (member_act != MEMBER_FWD_LEARN);

  // Reserved group trap only in double tag mode; otherwise untouched
  wire       rsv_trap    = dt_on & rsv_group & ~rsv_flood;
  wire       rsv_flood_d = dt_on & rsv_group & rsv_flood;

  wire       inv_drop    = vid_invalid & invalid_drop;
  wire       inv_mgmt    = vid_invalid & ~invalid_drop;
  wire       ones_drop   = vid_ones & ~all_ones_fwd;

  wire       next_drop   = crc_bad | mem_drop | inv_drop | ones_drop;
  wire       next_mgmt   = ~next_drop & (mem_mgmt | inv_mgmt |
                           (is_gvrp_i & gvrp_trap) |
                           (is_gmrp_i & gmrp_trap) | rsv_trap);
  wire       next_learn  = ~next_drop & ~mem_nolearn & ~from_mgmt_i;
  wire       next_keep   = tag_keep & ~dt_on & ~is_1q_tagged_i;
  wire       next_trunk  = ~(from_mgmt_i & egress_directed_i & trunk_skip);

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      decision_valid_o <= 1'b0;
      drop_o           <= 1'b0;
      to_mgmt_o        <= 1'b0;
      mgmt_only_o      <= 1'b0;
      learn_o          <= 1'b0;
      flood_rsv_o      <= 1'b0;
      keep_tag_o       <= 1'b0;
      trunk_check_o    <= 1'b0;
      double_tag_o     <= 1'b0;
    end else begin
      decision_valid_o <= frame_valid_i;
      drop_o           <= frame_valid_i & next_drop;
      to_mgmt_o        <= frame_valid_i & next_mgmt;
      mgmt_only_o      <= frame_valid_i & next_mgmt & rsv_trap;
      learn_o          <= frame_valid_i & next_learn;
      flood_rsv_o      <= frame_valid_i & ~next_drop & rsv_flood_d;
      keep_tag_o       <= frame_valid_i & next_keep;
      trunk_check_o    <= frame_valid_i & next_trunk;
      double_tag_o     <= dt_on;
    end
  end

  // Checks
  member_drop_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    frame_valid_i && !from_mgmt_i && vid_hit_i && !source_listed_i &&
    policy_four[7:6] == 2'b01 |=> drop_o && !learn_o)
    else $error("membership drop action not taken");

  mgmt_exempt_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    frame_valid_i && from_mgmt_i && crc_ok_i && vid_hit_i && vid_i != 12'hfff
    |=> !drop_o)
    else $error("management frame dropped by membership check");

  gvrp_trap_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    frame_valid_i && is_gvrp_i && policy_four[5] && !next_drop |=> to_mgmt_o)
    else $error("gvrp frame not sent to management");

  gmrp_trap_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    frame_valid_i && is_gmrp_i && policy_four[4] && !next_drop |=> to_mgmt_o)
    else $error("gmrp frame not sent to management");

  sequence dt_written_s;
    wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o &&
    wb_adr_i[9:2] == 8'h05 && wb_dat_i[3:2] == 2'b01;
  endsequence

  dt_enable_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    dt_written_s ##2 1'b1 |=> double_tag_o)
    else $error("double tag mode not enabled after write");

  rsv_trap_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    frame_valid_i && dt_on && !policy_four[1] && rsv_group && !next_drop
    |=> to_mgmt_o && mgmt_only_o && !flood_rsv_o)
    else $error("reserved multicast not trapped");

  rsv_range_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    dest_mac_i[47:8] == 40'h0180c20000 && dest_mac_i[7:0] == 8'h30 |-> !rsv_group)
    else $error("address above range classed reserved");

  keep_tag_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    frame_valid_i && !is_1q_tagged_i |=> keep_tag_o == ($past(tag_keep) && !double_tag_o))
    else $error("egress tag preservation wrong");

  trunk_skip_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    frame_valid_i && from_mgmt_i && egress_directed_i |=> trunk_check_o == !$past(trunk_skip))
    else $error("trunk check bypass wrong");

  invalid_vid_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    frame_valid_i && !vid_hit_i && !invalid_drop && crc_ok_i && vid_i != 12'hfff
    |=> to_mgmt_o && !drop_o)
    else $error("invalid vid not sent to management");

  all_ones_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    frame_valid_i && vid_i == 12'hfff && !all_ones_fwd |=> drop_o)
    else $error("vid fff frame not dropped");

  crc_skip_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    frame_valid_i && !crc_ok_i && !(from_mgmt_i && crc_skip) |=> drop_o)
    else $error("bad crc frame not dropped");

  no_dt_flood_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    frame_valid_i && !dt_on |=> !flood_rsv_o && !mgmt_only_o)
    else $error("reserved multicast handling changed outside double tag mode");

  // Bus shape and decision shape checks
  sequence bus_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence

  // A clean frame is one that no drop source can touch
  sequence clean_frame_s;
    frame_valid_i && vid_hit_i && source_listed_i && crc_ok_i && vid_i != VID_ALL_ONES;
  endsequence

  sequence member_fail_s(logic [1:0] act);
    frame_valid_i && !from_mgmt_i && vid_hit_i && !source_listed_i && crc_ok_i &&
    vid_i != VID_ALL_ONES && policy_four[MEMBER_ACT_HI:MEMBER_ACT_LO] == act;
  endsequence

  bus_answer_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    bus_req_s |=> wb_ack_o || wb_err_o)
    else $error("bus request not answered in the next cycle");

  answer_pulse_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    wb_ack_o || wb_err_o |=> !wb_ack_o && !wb_err_o)
    else $error("bus answer held longer than one cycle");

  answer_excl_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    !(wb_ack_o && wb_err_o))
    else $error("ack and err raised together");

  unmapped_err_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    bus_req_s && !hit_any |=> wb_err_o && !wb_ack_o)
    else $error("unmapped address not answered with err");

  idle_data_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    !wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data not zero outside an ack cycle");

  upper_zero_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    wb_dat_o[31:8] == 24'h00_0000)
    else $error("read data upper bytes not zero");

  reserved_zero_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    ((policy_four & ~POLICY_FOUR_MASK) == 8'h00) && ((policy_five & ~POLICY_FIVE_MASK) == 8'h00))
    else $error("reserved register bit set");

  lane_off_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    bus_req_s && wb_we_i && !wb_sel_i[0] |=> $stable(policy_four) && $stable(policy_five))
    else $error("write without lane 0 changed a register");

  four_write_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    bus_req_s && wb_we_i && wb_sel_i[0] && hit_four |=>
    policy_four == ($past(wb_dat_i[7:0]) & POLICY_FOUR_MASK))
    else $error("fourth register write not stored");

  five_write_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    bus_req_s && wb_we_i && wb_sel_i[0] && hit_five |=>
    policy_five == ($past(wb_dat_i[7:0]) & POLICY_FIVE_MASK))
    else $error("fifth register write not stored");

  decision_pulse_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    frame_valid_i |=> decision_valid_o)
    else $error("decision not given in the next cycle");

  idle_quiet_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    !frame_valid_i |=> !decision_valid_o && !drop_o && !to_mgmt_o && !learn_o &&
    !flood_rsv_o && !keep_tag_o && !trunk_check_o && !mgmt_only_o)
    else $error("decision outputs active without a frame");

  drop_excl_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    drop_o |-> !to_mgmt_o && !learn_o && !flood_rsv_o)
    else $error("dropped frame also forwarded or learned");

  mgmt_only_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    mgmt_only_o |-> to_mgmt_o)
    else $error("cpu-only trap without management forward");

  listed_learn_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    clean_frame_s ##0 !from_mgmt_i |=> learn_o && !drop_o)
    else $error("member source not learned");

  member_learn_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    member_fail_s(2'b10) |=> learn_o && !drop_o)
    else $error("membership forward-and-learn action not taken");

  member_mgmt_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    member_fail_s(2'b11) |=> to_mgmt_o && !learn_o && !drop_o)
    else $error("membership management action not taken");

  member_nolearn_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    member_fail_s(2'b00) |=> !drop_o && !learn_o)
    else $error("membership forward-no-learn action not taken");

  mgmt_nolearn_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    frame_valid_i && from_mgmt_i |=> !learn_o)
    else $error("management frame source learned");

  gvrp_off_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    clean_frame_s ##0 (is_gvrp_i && !is_gmrp_i && !policy_four[GVRP_TRAP_BIT] && !rsv_group)
    |=> !to_mgmt_o)
    else $error("gvrp frame sent to management while disabled");

  gmrp_off_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    clean_frame_s ##0 (is_gmrp_i && !is_gvrp_i && !policy_four[GMRP_TRAP_BIT] && !rsv_group)
    |=> !to_mgmt_o)
    else $error("gmrp frame sent to management while disabled");

  dt_level_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    1'b1 |=> double_tag_o == $past(policy_four[DT_SEL_HI:DT_SEL_LO] == DT_SEL_ON))
    else $error("double tag mode does not follow its select field");

  rsv_flood_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    clean_frame_s ##0 (dt_on && policy_four[RSV_FLOOD_BIT] && rsv_group)
    |=> flood_rsv_o && !mgmt_only_o)
    else $error("reserved multicast not flooded");

  rsv_edges_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    dest_mac_i[47:8] == RSV_PREFIX && (dest_mac_i[7:0] == 8'h00 || dest_mac_i[7:0] == 8'h2f)
    |-> rsv_group)
    else $error("reserved group end point not classed reserved");

  rsv_gap_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    dest_mac_i[47:8] == RSV_PREFIX && dest_mac_i[7:0] == 8'h01 |-> !rsv_group)
    else $error("address in the gap classed reserved");

  tagged_nokeep_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    frame_valid_i && is_1q_tagged_i |=> !keep_tag_o)
    else $error("tag preservation applied to a tagged frame");

  trunk_other_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    frame_valid_i && !(from_mgmt_i && egress_directed_i) |=> trunk_check_o)
    else $error("trunk check skipped for an ordinary frame");

  invalid_drop_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    frame_valid_i && !vid_hit_i && invalid_drop |=> drop_o && !to_mgmt_o)
    else $error("invalid vid frame not dropped");

  all_ones_fwd_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    frame_valid_i && vid_ones && all_ones_fwd && vid_hit_i && source_listed_i && crc_ok_i
    |=> !drop_o)
    else $error("vid fff frame dropped while forwarding enabled");

  crc_keep_a : assert property (@(posedge clk_i) disable iff (!rstn_i)
    frame_valid_i && from_mgmt_i && !crc_ok_i && crc_skip && vid_hit_i && !vid_ones
    |=> !drop_o)
    else $error("management frame dropped for crc while bypassed");

endmodule

// File: test/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import vlan_policy_pkg::*;

  logic        clk_i, rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, frame_valid_i, from_mgmt_i;
  logic        vid_hit_i, source_listed_i, is_gvrp_i, is_gmrp_i, is_1q_tagged_i;
  logic        egress_directed_i, crc_ok_i, wb_ack_o, wb_err_o, decision_valid_o, drop_o;
  logic        to_mgmt_o, mgmt_only_o, learn_o, flood_rsv_o, keep_tag_o, trunk_check_o;
  logic        double_tag_o, er;
  logic [9:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [47:0] dest_mac_i;
  logic [11:0] vid_i;
  int          miscompares, comparisons;
  // Unicast address outside the reserved group range
  localparam logic [47:0] PLAIN = 48'h00a0b0c0d0e0;

  vlan_global_policy_ctrl u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .frame_valid_i(frame_valid_i), .from_mgmt_i(from_mgmt_i), .dest_mac_i(dest_mac_i),
    .vid_i(vid_i), .vid_hit_i(vid_hit_i), .source_listed_i(source_listed_i),
    .is_gvrp_i(is_gvrp_i), .is_gmrp_i(is_gmrp_i), .is_1q_tagged_i(is_1q_tagged_i),
    .egress_directed_i(egress_directed_i), .crc_ok_i(crc_ok_i),
    .decision_valid_o(decision_valid_o), .drop_o(drop_o), .to_mgmt_o(to_mgmt_o),
    .mgmt_only_o(mgmt_only_o), .learn_o(learn_o), .flood_rsv_o(flood_rsv_o),
    .keep_tag_o(keep_tag_o), .trunk_check_o(trunk_check_o), .double_tag_o(double_tag_o));

  task automatic complete_run();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Classic single cycle; request held until ack or err is sampled high
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    if (n >= 20) chk("bus_answer", 1, 0);
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk_i);
  endtask

  // f holds {hit, listed, gvrp, gmrp, tagged, egress, crc_ok}
  task automatic fr(input logic mg, input logic [47:0] da, input logic [11:0] vid,
                    input logic [6:0] f);
    from_mgmt_i   <= mg;
    dest_mac_i    <= da;
    vid_i         <= vid;
    {vid_hit_i, source_listed_i, is_gvrp_i, is_gmrp_i, is_1q_tagged_i, egress_directed_i,
     crc_ok_i}    <= f;
    frame_valid_i <= 1'b1;
    @(posedge clk_i);
    frame_valid_i <= 1'b0;
    // Decision launched at the previous edge is sampled here, still standing
    @(posedge clk_i);
    chk("decision_valid", 1, decision_valid_o);
  endtask

  task automatic t_regs();
    bus(0, 8'h05, 0); chk("four_reset", 8'hc0, rd);
    bus(0, 8'h06, 0); chk("five_reset", 8'h10, rd);
    bus(0, 8'h07, 0); chk("unmapped_err", 1, er);
    bus(1, 8'h05, 8'hff); bus(0, 8'h05, 0); chk("four_rw", 8'hfe, rd);
    wb_sel_i <= 4'h0;
    bus(1, 8'h05, 8'h00);
    wb_sel_i <= 4'h1;
    bus(0, 8'h05, 0); chk("sel_off_keep", 8'hfe, rd);
    bus(1, 8'h06, 8'hff); bus(0, 8'h06, 0); chk("five_rw", 8'h5d, rd);
    bus(1, 8'h06, 8'h10);
  endtask

  task automatic t_member();
    for (int i = 0; i < 4; i++) begin
      bus(1, 8'h05, 8'(i << 6));
      fr(0, PLAIN, 12'h001, 7'h45);
      chk("member_drop", i == 1, drop_o);
      chk("member_mgmt", i == 3, to_mgmt_o);
      chk("member_learn", i == 2, learn_o);
    end
    bus(1, 8'h05, 8'h40);
    fr(0, PLAIN, 12'h001, 7'h65); chk("listed_pass", 0, drop_o);
    fr(1, PLAIN, 12'h001, 7'h45); chk("mgmt_exempt", 0, drop_o);
  endtask

  task automatic t_garp();
    for (int i = 0; i < 2; i++) begin
      bus(1, 8'h05, i ? 8'h10 : 8'h20);
      fr(0, PLAIN, 12'h001, 7'h75); chk("gvrp_mgmt", i == 0, to_mgmt_o);
      fr(0, PLAIN, 12'h001, 7'h6d); chk("gmrp_mgmt", i == 1, to_mgmt_o);
    end
  endtask

  task automatic t_dtag();
    logic [7:0] lo [5] = '{8'h00, 8'h01, 8'h02, 8'h2f, 8'h30};
    bus(1, 8'h06, 8'h40);
    bus(1, 8'h05, 8'h00);
    fr(0, PLAIN, 12'h001, 7'h61); chk("keep_tag", 1, keep_tag_o);
    chk("dt_off", 0, double_tag_o);
    bus(1, 8'h05, 8'h04);
    fr(0, PLAIN, 12'h001, 7'h61); chk("keep_tag_dt", 0, keep_tag_o);
    chk("dt_on", 1, double_tag_o);
    for (int i = 0; i < 5; i++) begin
      fr(0, {40'h0180c20000, lo[i]}, 12'h001, 7'h65);
      chk("rsv_trap", i != 1 && i != 4, mgmt_only_o);
    end
    bus(1, 8'h05, 8'h06);
    fr(0, 48'h0180c2000000, 12'h001, 7'h65); chk("rsv_flood", 1, flood_rsv_o);
    chk("rsv_flood_trap", 0, mgmt_only_o);
    bus(1, 8'h05, 8'h02);
    fr(0, 48'h0180c2000000, 12'h001, 7'h65); chk("rsv_no_dt", 0, flood_rsv_o);
    chk("rsv_no_dt_trap", 0, mgmt_only_o);
    bus(1, 8'h05, 8'h08);
    fr(0, PLAIN, 12'h001, 7'h65); chk("dt_reserved_code", 0, double_tag_o);
  endtask

  task automatic t_five();
    bus(1, 8'h05, 8'h00);
    for (int i = 0; i < 2; i++) begin
      bus(1, 8'h06, i ? 8'h1d : 8'h00);
      fr(1, PLAIN, 12'h001, 7'h67); chk("trunk_check", !i, trunk_check_o);
      fr(0, PLAIN, 12'h001, 7'h25); chk("invalid_drop", i, drop_o);
      chk("invalid_mgmt", !i, to_mgmt_o);
      fr(0, PLAIN, 12'hfff, 7'h65); chk("all_ones_drop", !i, drop_o);
      fr(1, PLAIN, 12'h001, 7'h64); chk("crc_drop", !i, drop_o);
    end
  endtask

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Whole run is well under a thousand cycles
  initial begin
    #100us;
    miscompares++;
    complete_run();
  end

  initial begin
    {rstn_i, wb_cyc_i, wb_stb_i, wb_we_i, frame_valid_i, from_mgmt_i} = '0;
    {vid_hit_i, source_listed_i, is_gvrp_i, is_gmrp_i} = '0;
    {is_1q_tagged_i, egress_directed_i, crc_ok_i} = '0;
    {wb_adr_i, wb_sel_i, wb_dat_i, dest_mac_i, vid_i} = '0;
    wb_sel_i = 4'h1;
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    t_regs();
    t_member();
    t_garp();
    t_dtag();
    t_five();
    complete_run();
  end
endmodule
